// ===== include/mpg_pkg.sv
// package: constants, register map and carrier types of the metering pulse generator
`default_nettype none
package mpg_pkg;
    // register indices (byte address is four times the index)
    localparam int MPG_IDX_MAX_WIDTH = 32'h0000_210a;
    localparam int MPG_IDX_INTERVAL = 32'h0000_210b;
    localparam int MPG_IDX_POLARITY = 32'h0000_210c;
    localparam int MPG_IDX_IRQ_STATUS = 32'h0000_2110;
    localparam int MPG_IDX_IRQ_MASK = 32'h0000_2111;
    localparam int MPG_IDX_PULSE_STATE = 32'h0000_2112;
    localparam int MPG_IDX_OPT_SELECT = 32'h0000_2456;
    localparam logic [15:0] MPG_ADDR_MAX_WIDTH = 16'(MPG_IDX_MAX_WIDTH * 4);
    localparam logic [15:0] MPG_ADDR_INTERVAL = 16'(MPG_IDX_INTERVAL * 4);
    localparam logic [15:0] MPG_ADDR_POLARITY = 16'(MPG_IDX_POLARITY * 4);
    localparam logic [15:0] MPG_ADDR_IRQ_STATUS = 16'(MPG_IDX_IRQ_STATUS * 4);
    localparam logic [15:0] MPG_ADDR_IRQ_MASK = 16'(MPG_IDX_IRQ_MASK * 4);
    localparam logic [15:0] MPG_ADDR_PULSE_STATE = 16'(MPG_IDX_PULSE_STATE * 4);
    localparam logic [15:0] MPG_ADDR_OPT_SELECT = 16'(MPG_IDX_OPT_SELECT * 4);
    // field positions
    localparam int MPG_POL_INVERT_BIT = 0;
    localparam int MPG_OPT_SEL_LSB = 2;
    // reset values
    localparam logic [7:0] MPG_RST_MAX_WIDTH = 8'hff;
    localparam logic [7:0] MPG_RST_INTERVAL = 8'h00;
    localparam logic MPG_RST_POLARITY = 1'b0;
    localparam logic [1:0] MPG_RST_OPT_SELECT = 2'h0;
    localparam logic [3:0] MPG_RST_IRQ_MASK = 4'h0;
    // timing: one interval count is four filter-clock cycles
    localparam int MPG_CYCLES_PER_COUNT = 4;
    localparam logic [1:0] MPG_DIV_LAST = 2'(MPG_CYCLES_PER_COUNT - 1);
    localparam logic [7:0] MPG_WIDTH_NO_LIMIT = 8'hff;
    // energy FIFO geometry
    localparam int MPG_FIFO_DEPTH = 8;
    localparam int MPG_FIFO_AW = 3;
    // pulse index in status, mask and state registers
    localparam int MPG_P_ENERGY_A = 0;
    localparam int MPG_P_ENERGY_B = 1;
    localparam int MPG_P_STATUS_A = 2;
    localparam int MPG_P_STATUS_B = 3;

    // optical transmit pin source
    typedef enum logic [1:0] {
        MPG_OPT_NORMAL = 2'b00,
        MPG_OPT_ENERGY_A = 2'b01,
        MPG_OPT_ENERGY_B = 2'b10,
        MPG_OPT_BOTH = 2'b11
    } mpg_opt_sel_t;

    // bits exported by the compute engine, all on clk
    typedef struct packed {
        logic frame_start;
        logic pass_start;
        logic energy_valid;
        logic energy_a;
        logic energy_b;
        logic status_valid;
        logic status_a;
        logic status_b;
    } mpg_export_t;
endpackage
`default_nettype wire

// ===== rtl/mpg_pulse_gen.sv
// metering pulse output generator: energy FIFO, interval pacing, width limit, APB registers
//
// Functional notes
// - each of four pulse outputs can raise an interrupt when it pulses
// - one polarity bit inverts all pulse outputs; one means active high
// - polarity bit resets to zero, outputs idle high, pulse low
// - status pulses follow engine bits, at most one update per pass
// - energy sign bits of a pass go into an eight-entry FIFO
// - energy FIFO is cleared at the start of each multiplexer frame
// - interval register sets first-update delay and spacing of updates
// - one interval count equals four filter-clock cycles
// - interval zero bypasses the FIFO; energy outputs follow sign bits
// - updates not released before frame end are lost by the clear
// - width register limits active width to (2*value+1) intervals
// - width 255 or interval zero applies no limit
// - energy outputs drive their own segment/IO pins
// - two-bit select routes pulses to the optical transmit pin
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mpg_pulse_gen (
    // clock and reset (clk is the filter clock)
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // compute engine export
    input wire mpg_pkg::mpg_export_t ce_export,
    input wire logic opt_normal_data,
    // pins
    output logic seg_io_pin_0,
    output logic seg_io_pin_1,
    output logic seg_io_pin_6,
    output logic seg_io_pin_7,
    output logic optical_transmit_pin,
    // interrupt
    output logic irq
);
    logic [7:0] pulse_max_width;
    logic [7:0] pulse_update_interval;
    logic pulse_polarity_invert;
    logic [1:0] optical_output_select;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [1:0] fifo_mem [mpg_pkg::MPG_FIFO_DEPTH];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] fifo_count;
    logic [1:0] div_cnt;
    logic [7:0] slot_cnt;
    logic [1:0] energy_raw;
    logic [1:0] energy_act;
    logic [1:0] status_act;
    logic status_done;
    logic [3:0] act_prev;
    logic [3:0] pulse_act;
    logic [3:0] pulse_rise;
    logic quarter_tick;
    logic slot_event;
    logic fifo_on;
    logic width_on;
    logic fifo_push;
    logic fifo_pop;
    logic apb_write;
    logic apb_read;
    logic next_opt;
    logic [31:0] next_rdata;
    logic next_err;

    localparam logic [3:0] FIFO_FULL = 4'(mpg_pkg::MPG_FIFO_DEPTH);

    assign fifo_on = (pulse_update_interval != 8'h00);
    assign width_on = fifo_on && (pulse_max_width != mpg_pkg::MPG_WIDTH_NO_LIMIT);
    assign apb_write = psel && penable && pready && pwrite;
    assign apb_read = psel && penable && !pready && !pwrite;
    assign pulse_act = {status_act, energy_act};
    assign pulse_rise = pulse_act & ~act_prev;

    // apb handshake: one wait state, answer on second access cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= apb_read ? next_rdata : 32'h0000_0000;
                pslverr <= next_err;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // read mux and address decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            mpg_pkg::MPG_ADDR_MAX_WIDTH: next_rdata[7:0] = pulse_max_width;
            mpg_pkg::MPG_ADDR_INTERVAL: next_rdata[7:0] = pulse_update_interval;
            mpg_pkg::MPG_ADDR_POLARITY:
                next_rdata[mpg_pkg::MPG_POL_INVERT_BIT] = pulse_polarity_invert;
            mpg_pkg::MPG_ADDR_IRQ_STATUS: next_rdata[3:0] = irq_status;
            mpg_pkg::MPG_ADDR_IRQ_MASK: next_rdata[3:0] = irq_mask;
            mpg_pkg::MPG_ADDR_PULSE_STATE: next_rdata[7:0] = {fifo_count, pulse_act};
            mpg_pkg::MPG_ADDR_OPT_SELECT:
                next_rdata[mpg_pkg::MPG_OPT_SEL_LSB +: 2] = optical_output_select;
            default: next_err = 1'b1;
        endcase
    end

    // control registers written by software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_max_width <= mpg_pkg::MPG_RST_MAX_WIDTH;
            pulse_update_interval <= mpg_pkg::MPG_RST_INTERVAL;
            pulse_polarity_invert <= mpg_pkg::MPG_RST_POLARITY;
            optical_output_select <= mpg_pkg::MPG_RST_OPT_SELECT;
            irq_mask <= mpg_pkg::MPG_RST_IRQ_MASK;
        end else if (apb_write) begin
            case (paddr)
                mpg_pkg::MPG_ADDR_MAX_WIDTH: pulse_max_width <= pwdata[7:0];
                mpg_pkg::MPG_ADDR_INTERVAL: pulse_update_interval <= pwdata[7:0];
                mpg_pkg::MPG_ADDR_POLARITY:
                    pulse_polarity_invert <= pwdata[mpg_pkg::MPG_POL_INVERT_BIT];
                mpg_pkg::MPG_ADDR_OPT_SELECT:
                    optical_output_select <= pwdata[mpg_pkg::MPG_OPT_SEL_LSB +: 2];
                mpg_pkg::MPG_ADDR_IRQ_MASK: irq_mask <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // sticky pulse events, write one to clear, a new event wins over the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= 4'h0;
            act_prev <= 4'h0;
            irq <= 1'b0;
        end else begin
            act_prev <= pulse_act;
            if (apb_write && paddr == mpg_pkg::MPG_ADDR_IRQ_STATUS) begin
                irq_status <= (irq_status & ~pwdata[3:0]) | pulse_rise;
            end else begin
                irq_status <= irq_status | pulse_rise;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // status pulses: first valid export of a pass wins, later ones ignored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_act <= 2'b00;
            status_done <= 1'b0;
        end else if (ce_export.pass_start) begin
            status_done <= 1'b0;
        end else if (ce_export.status_valid && !status_done) begin
            status_act <= {ce_export.status_b, ce_export.status_a};
            status_done <= 1'b1;
        end
    end

    // quarter-rate divider and interval slot counter, restarted at frame start
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 2'b00;
            slot_cnt <= 8'h00;
        end else if (ce_export.frame_start || !fifo_on) begin
            div_cnt <= 2'b00;
            slot_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 2'b01;
            if (quarter_tick) begin
                slot_cnt <= slot_event ? 8'h00 : slot_cnt + 8'h01;
            end
        end
    end
    assign quarter_tick = (div_cnt == mpg_pkg::MPG_DIV_LAST);
    assign slot_event = fifo_on && !ce_export.frame_start && quarter_tick
        && (slot_cnt + 8'h01 == pulse_update_interval);

    // energy FIFO: filled during the pass, drained one entry per slot
    assign fifo_push = fifo_on && ce_export.energy_valid && (fifo_count != FIFO_FULL);
    assign fifo_pop = slot_event && (fifo_count != 4'h0);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            fifo_count <= 4'h0;
        end else if (ce_export.frame_start || !fifo_on) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            fifo_count <= 4'h0;
        end else begin
            if (fifo_push) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (fifo_pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            fifo_count <= fifo_count + 4'(fifo_push) - 4'(fifo_pop);
        end
    end

    // FIFO storage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < mpg_pkg::MPG_FIFO_DEPTH; i++) begin
                fifo_mem[i] <= 2'b00;
            end
        end else if (fifo_push) begin
            fifo_mem[wr_ptr] <= {ce_export.energy_b, ce_export.energy_a};
        end
    end

    // raw energy level: FIFO output, or the sign bits directly in bypass
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            energy_raw <= 2'b00;
        end else if (!fifo_on) begin
            if (ce_export.energy_valid) begin
                energy_raw <= {ce_export.energy_b, ce_export.energy_a};
            end
        end else if (fifo_pop) begin
            energy_raw <= fifo_mem[rd_ptr];
        end
    end

    // per-channel width limit counted in update intervals
    for (genvar ch = 0; ch < 2; ch++) begin : g_width
        logic [8:0] width_cnt;
        logic cut;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                width_cnt <= 9'h000;
                cut <= 1'b0;
            end else if (!energy_raw[ch] || !width_on) begin
                width_cnt <= 9'h000;
                cut <= 1'b0;
            end else if (slot_event) begin
                if (fifo_pop && !fifo_mem[rd_ptr][ch]) begin
                    width_cnt <= 9'h000;
                    cut <= 1'b0;
                end else if (!cut) begin
                    width_cnt <= width_cnt + 9'h001;
                    cut <= (width_cnt + 9'h001 == {pulse_max_width, 1'b1});
                end
            end
        end
        assign energy_act[ch] = energy_raw[ch] && !cut;
    end

    // optical pin source
    always_comb begin
        case (mpg_pkg::mpg_opt_sel_t'(optical_output_select))
            mpg_pkg::MPG_OPT_NORMAL: next_opt = opt_normal_data;
            mpg_pkg::MPG_OPT_ENERGY_A: next_opt = pulse_polarity_invert == energy_act[0];
            mpg_pkg::MPG_OPT_ENERGY_B: next_opt = pulse_polarity_invert == energy_act[1];
            mpg_pkg::MPG_OPT_BOTH: next_opt = pulse_polarity_invert == (|energy_act);
            default: next_opt = opt_normal_data;
        endcase
    end

    // pin registers: pulses active low unless the invert bit is set; optical pin passes normal data at select zero and resets low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seg_io_pin_0 <= 1'b1;
            seg_io_pin_1 <= 1'b1;
            seg_io_pin_6 <= 1'b1;
            seg_io_pin_7 <= 1'b1;
            optical_transmit_pin <= 1'b0;
        end else begin
            seg_io_pin_0 <= pulse_polarity_invert == energy_act[0];
            seg_io_pin_1 <= pulse_polarity_invert == energy_act[1];
            seg_io_pin_6 <= pulse_polarity_invert == status_act[0];
            seg_io_pin_7 <= pulse_polarity_invert == status_act[1];
            optical_transmit_pin <= next_opt;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/mpg_engine_model.sv
// compute engine model: one-cycle export strobes, data bits inverted while idle
`timescale 1ns/1ns
`default_nettype none
module mpg_engine_model (
    // clock and export
    input wire logic clk,
    output var mpg_pkg::mpg_export_t ce_export
);
    initial ce_export = '0;
    // one strobe cycle, then idle with the data bits inverted so stale sign bits read wrong
    task send(input mpg_pkg::mpg_export_t v);
        @(posedge clk);
        ce_export <= v;
        @(posedge clk);
        ce_export <= ~v & 8'h1b;
    endtask
    task frame; send(8'h80); endtask
    task pass; send(8'h40); endtask
    task push(input logic a, input logic b); send({3'b001, a, b, 3'b000}); endtask
    task stat(input logic a, input logic b); send({5'b00000, 1'b1, a, b}); endtask
endmodule
`default_nettype wire

// ===== testbench/mpg_pulse_gen_props.sv
// checker: apb timing, bypass path, optical routing of normal data and interrupt masking
`timescale 1ns/1ns
`default_nettype none
module mpg_pulse_gen_props (
    // clock, reset and apb
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // engine export, pins and interrupt
    input wire mpg_pkg::mpg_export_t ce_export,
    input wire logic opt_normal_data,
    input wire logic seg_io_pin_0,
    input wire logic seg_io_pin_1,
    input wire logic optical_transmit_pin,
    input wire logic irq
);
    logic [7:0] intv;
    logic inv;
    logic [1:0] osel;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // copies of the registers, updated by completed apb writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intv <= mpg_pkg::MPG_RST_INTERVAL;
            inv <= mpg_pkg::MPG_RST_POLARITY;
            osel <= mpg_pkg::MPG_RST_OPT_SELECT;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == mpg_pkg::MPG_ADDR_INTERVAL)
                intv <= pwdata[7:0];
            if (paddr == mpg_pkg::MPG_ADDR_POLARITY)
                inv <= pwdata[0];
            if (paddr == mpg_pkg::MPG_ADDR_OPT_SELECT)
                osel <= pwdata[3:2];
        end
    end
    // assertions
    pready_once_a: assert property (pready |=> !pready)
        else $error("pready high two cycles");
    apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr without pready");
    err_data_a: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
        else $error("read data not zero");
    bypass_follow_a: assert property (intv == 8'h00 && ce_export.energy_valid |-> ##2
        seg_io_pin_0 == ($past(ce_export.energy_a, 2) == inv)
        && seg_io_pin_1 == ($past(ce_export.energy_b, 2) == inv))
        else $error("bypass pin wrong");
    opt_normal_a: assert property ($past(osel) == 2'h0 && $past(arst_n)
        |-> optical_transmit_pin == $past(opt_normal_data))
        else $error("optical pin not passing normal data");
    irq_mask_a: assert property (psel && penable && pready && pwrite
        && paddr == mpg_pkg::MPG_ADDR_IRQ_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq high with all masked");
    // main scenarios
    fifo_frame_c: cover property (intv != 8'h00 && ce_export.frame_start);
    irq_rise_c: cover property ($rose(irq));
    slverr_c: cover property (pslverr);
endmodule
bind mpg_pulse_gen mpg_pulse_gen_props mpg_pulse_gen_props_i (.clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ce_export, .opt_normal_data,
    .seg_io_pin_0, .seg_io_pin_1, .optical_transmit_pin, .irq);
`default_nettype wire

// ===== testbench/tb.sv
// testbench: drives the pulse generator over apb and through the engine model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("Error %0t: got %h want %h", $time, a, e); end end
module tb;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic opt_normal_data = 1'b0, pready, pslverr, rerr, irq, optical_transmit_pin;
    logic seg_io_pin_0, seg_io_pin_1, seg_io_pin_6, seg_io_pin_7;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pins;
    mpg_pkg::mpg_export_t ce_export;
    int errors = 0, checks = 0;
    assign pins = {seg_io_pin_0, seg_io_pin_1, seg_io_pin_6, seg_io_pin_7};
    always #25 clk = ~clk;
    mpg_pulse_gen mpg_pulse_gen_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ce_export, .opt_normal_data, .seg_io_pin_0, .seg_io_pin_1,
        .seg_io_pin_6, .seg_io_pin_7, .optical_transmit_pin, .irq);
    mpg_engine_model mpg_engine_model_i (.clk, .ce_export);
    // wait n edges, then sample past the update
    task tick(input int n); repeat (n) @(posedge clk); #1; endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        `CHK(pready, 1'b1)
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task rd(input logic [15:0] a); apb(1'b0, a, 32'h0); endtask
    // reset values, idle pins and an unmapped read
    task t_reset;
        rd(mpg_pkg::MPG_ADDR_MAX_WIDTH);
        `CHK(rdat, 32'h0000_00ff)
        rd(mpg_pkg::MPG_ADDR_INTERVAL);
        `CHK(rdat, 32'h0)
        rd(mpg_pkg::MPG_ADDR_POLARITY);
        `CHK(rdat, 32'h0)
        `CHK(pins, 4'hf)
        rd(16'h0004);
        `CHK({rerr, rdat}, 33'h1_0000_0000)
        $display("t_reset done");
    endtask
    // bypass path and global inversion
    task t_bypass;
        mpg_engine_model_i.push(1'b1, 1'b0);
        tick(3);
        `CHK(pins[3:2], 2'b01)
        wr(mpg_pkg::MPG_ADDR_POLARITY, 32'h1);
        tick(3);
        `CHK(pins[3:2], 2'b10)
        wr(mpg_pkg::MPG_ADDR_POLARITY, 32'h0);
        mpg_engine_model_i.push(1'b0, 1'b0);
        tick(3);
        `CHK(pins[3:2], 2'b11)
        $display("t_bypass done");
    endtask
    // status pins take one update per pass
    task t_status;
        mpg_engine_model_i.pass;
        mpg_engine_model_i.stat(1'b1, 1'b1);
        tick(3);
        `CHK(pins[1:0], 2'b00)
        mpg_engine_model_i.stat(1'b0, 1'b0);
        tick(3);
        `CHK(pins[1:0], 2'b00)
        mpg_engine_model_i.pass;
        mpg_engine_model_i.stat(1'b0, 1'b0);
        tick(3);
        `CHK(pins[1:0], 2'b11)
        $display("t_status done");
    endtask
    // paced fifo release, then a frame clear that drops the last entry
    task t_fifo;
        wr(mpg_pkg::MPG_ADDR_INTERVAL, 32'h2);
        mpg_engine_model_i.frame;
        mpg_engine_model_i.push(1'b1, 1'b0);
        mpg_engine_model_i.push(1'b0, 1'b1);
        mpg_engine_model_i.push(1'b1, 1'b1);
        tick(1);
        `CHK(pins[3:2], 2'b11)
        tick(4);
        `CHK(pins[3:2], 2'b01)
        tick(4);
        `CHK(pins[3:2], 2'b01)
        tick(4);
        `CHK(pins[3:2], 2'b10)
        mpg_engine_model_i.frame;
        tick(12);
        `CHK(pins[3:2], 2'b10)
        $display("t_fifo done");
    endtask
    // width limit of three intervals, then no limit at 255
    task t_width;
        wr(mpg_pkg::MPG_ADDR_MAX_WIDTH, 32'h1);
        wr(mpg_pkg::MPG_ADDR_INTERVAL, 32'h1);
        mpg_engine_model_i.frame;
        mpg_engine_model_i.push(1'b1, 1'b0);
        tick(9);
        `CHK(pins[3], 1'b0)
        tick(10);
        `CHK(pins[3:2], 2'b11)
        wr(mpg_pkg::MPG_ADDR_MAX_WIDTH, 32'hff);
        mpg_engine_model_i.frame;
        mpg_engine_model_i.push(1'b1, 1'b0);
        tick(40);
        `CHK(pins[3], 1'b0)
        mpg_engine_model_i.frame;
        mpg_engine_model_i.push(1'b0, 1'b0);
        tick(12);
        wr(mpg_pkg::MPG_ADDR_INTERVAL, 32'h0);
        $display("t_width done");
    endtask
    // interrupt raised, masked, unmasked and cleared
    task t_irq;
        wr(mpg_pkg::MPG_ADDR_IRQ_STATUS, 32'hf);
        wr(mpg_pkg::MPG_ADDR_IRQ_MASK, 32'h1);
        tick(3);
        `CHK(irq, 1'b0)
        mpg_engine_model_i.push(1'b1, 1'b0);
        tick(5);
        `CHK(irq, 1'b1)
        rd(mpg_pkg::MPG_ADDR_IRQ_STATUS);
        `CHK(rdat[0], 1'b1)
        rd(mpg_pkg::MPG_ADDR_PULSE_STATE);
        `CHK(rdat, 32'h0000_0001)
        wr(mpg_pkg::MPG_ADDR_IRQ_MASK, 32'h0);
        wr(mpg_pkg::MPG_ADDR_IRQ_MASK, 32'h1);
        tick(3);
        `CHK(irq, 1'b1)
        wr(mpg_pkg::MPG_ADDR_IRQ_STATUS, 32'h1);
        tick(3);
        `CHK(irq, 1'b0)
        $display("t_irq done");
    endtask
    // optical pin sources with energy a active and energy b idle
    task t_opt;
        @(posedge clk);
        opt_normal_data <= 1'b1;
        tick(3);
        `CHK(optical_transmit_pin, 1'b1)
        wr(mpg_pkg::MPG_ADDR_OPT_SELECT, 32'h4);
        tick(3);
        `CHK(optical_transmit_pin, 1'b0)
        wr(mpg_pkg::MPG_ADDR_OPT_SELECT, 32'h8);
        tick(3);
        `CHK(optical_transmit_pin, 1'b1)
        wr(mpg_pkg::MPG_ADDR_OPT_SELECT, 32'hc);
        tick(3);
        `CHK(optical_transmit_pin, 1'b0)
        $display("t_opt done");
    endtask
    // verdict and end of run
    task finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        tick(1);
        t_reset;
        t_bypass;
        t_status;
        t_fifo;
        t_width;
        t_irq;
        t_opt;
        finish_test;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        finish_test;
    end
endmodule
`default_nettype wire
